/* File: include/t2ar_defines.svh */
// register map, field positions, reset values and timing counts of the reload timer
`ifndef T2AR_DEFINES_SVH
`define T2AR_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define T2AR_OFS_CTRL      8'h00
`define T2AR_OFS_STATUS    8'h04
`define T2AR_OFS_CLEAR     8'h08
`define T2AR_OFS_IRQ_EN    8'h0C
`define T2AR_OFS_RELOAD    8'h10
`define T2AR_OFS_COUNT     8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define T2AR_CTRL_RUN      0
`define T2AR_CTRL_EXTEN    1
`define T2AR_CTRL_DIREN    2
`define T2AR_FLAG_OVF      0
`define T2AR_FLAG_EXT      1

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define T2AR_CTRL_RST      3'h0
`define T2AR_RELOAD_RST    16'h0000
`define T2AR_COUNT_RST     16'h0000
`define T2AR_COUNT_TOP     16'hFFFF
`define T2AR_CLKS_PER_TICK 12

`endif

/* File: include/t2ar_pkg.sv */
// types shared by the reload timer
package t2ar_pkg;

    // operating mode decoded from the control bits
    typedef enum logic [1:0]
    {
        T2AR_MODE_RELOAD  = 2'b00,
        T2AR_MODE_TRIGGER = 2'b01,
        T2AR_MODE_UPDOWN  = 2'b11
    } t2ar_mode_t;

    typedef logic [15:0] t2ar_word_t;

endpackage : t2ar_pkg

/* File: rtl/t2ar_timer.sv */
// 16-bit auto-reload up/down timer with apb register access
`timescale 1ns/10ps
`include "t2ar_defines.svh"

module t2ar_timer
#(
    parameter int CLKS_PER_TICK = `T2AR_CLKS_PER_TICK
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_trigger_pin,
    output t2ar_pkg::t2ar_word_t   count_value,
    output logic                   irq
);
    import t2ar_pkg::*;

    localparam int PW = (CLKS_PER_TICK > 1) ? $clog2(CLKS_PER_TICK) : 1;
    localparam logic [PW-1:0] PRE_LAST = PW'(CLKS_PER_TICK - 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [2:0]     ctrl_r;
    logic [1:0]     irq_en_r;
    t2ar_word_t     reload_r;
    t2ar_word_t     count_r;
    t2ar_word_t     count_nxt;
    logic           overflow_flag_r;
    logic           overflow_flag_nxt;
    logic           external_event_flag_r;
    logic           external_event_flag_nxt;
    logic           pin_prev_r;
    logic [PW-1:0]  pre_r;
    logic [31:0]    prdata_r;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_rd  = psel & ~penable & ~pwrite;
    wire acc_wr    = psel & penable & pwrite;
    wire hit_ctrl  = (paddr == `T2AR_OFS_CTRL);
    wire hit_stat  = (paddr == `T2AR_OFS_STATUS);
    wire hit_clr   = (paddr == `T2AR_OFS_CLEAR);
    wire hit_en    = (paddr == `T2AR_OFS_IRQ_EN);
    wire hit_rld   = (paddr == `T2AR_OFS_RELOAD);
    wire hit_cnt   = (paddr == `T2AR_OFS_COUNT);
    wire addr_ok   = hit_ctrl | hit_stat | hit_clr | hit_en | hit_rld | hit_cnt;
    wire wr_ctrl   = acc_wr & hit_ctrl;
    wire wr_clr    = acc_wr & hit_clr;
    wire wr_en     = acc_wr & hit_en;
    wire wr_rld    = acc_wr & hit_rld;
    wire wr_cnt    = acc_wr & hit_cnt;
    wire clr_ovf   = wr_clr & pwdata[`T2AR_FLAG_OVF];
    wire clr_ext   = wr_clr & pwdata[`T2AR_FLAG_EXT];

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata  = prdata_r;

    // ----------------------------------------------------------------
    // mode and count events
    // ----------------------------------------------------------------
    wire run_control_bit           = ctrl_r[`T2AR_CTRL_RUN];
    wire external_trigger_enable   = ctrl_r[`T2AR_CTRL_EXTEN];
    wire count_direction_enable    = ctrl_r[`T2AR_CTRL_DIREN];

    t2ar_mode_t mode;
    assign mode = count_direction_enable  ? T2AR_MODE_UPDOWN  :
                  external_trigger_enable ? T2AR_MODE_TRIGGER : T2AR_MODE_RELOAD;

    wire updown    = (mode == T2AR_MODE_UPDOWN);
    wire tick      = run_control_bit & (pre_r == PRE_LAST);
    wire count_up  = ~updown | external_trigger_pin;
    wire at_top    = (count_r == `T2AR_COUNT_TOP);
    wire at_bottom = (count_r == reload_r);
    wire wrap_up   = tick & count_up & at_top;
    wire wrap_dn   = tick & ~count_up & at_bottom;
    wire wrap_any  = wrap_up | wrap_dn;
    // falling edge only while trigger mode active
    wire trig_evt  = pin_prev_r & ~external_trigger_pin & (mode == T2AR_MODE_TRIGGER);
    // reload on overflow or trigger edge
    wire reload_ev = wrap_up | (trig_evt & run_control_bit);

    // ----------------------------------------------------------------
    // next count
    // ----------------------------------------------------------------
    always_comb
    begin
        if (wr_cnt)
            count_nxt = pwdata[15:0];
        else if (wrap_dn)
            count_nxt = `T2AR_COUNT_TOP;
        else if (reload_ev)
            count_nxt = reload_r;
        else if (tick)
            count_nxt = count_up ? count_r + 16'h0001 : count_r - 16'h0001;
        else
            count_nxt = count_r;
    end

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    always_comb
    begin
        // only software clears; set wins over clear
        overflow_flag_nxt = overflow_flag_r & ~clr_ovf;
        // overflow or underflow sets the flag
        if (wrap_any)
            overflow_flag_nxt = 1'b1;
        external_event_flag_nxt = external_event_flag_r & ~clr_ext;
        if (trig_evt)
            external_event_flag_nxt = 1'b1;
        // in up/down mode the seventeenth bit toggles on each wrap
        if (updown & wrap_any)
            external_event_flag_nxt = ~external_event_flag_r;
    end

    // ----------------------------------------------------------------
    // interrupt
    // ----------------------------------------------------------------
    // or of enabled flags, external flag gated in direction mode
    assign irq = (overflow_flag_r & irq_en_r[`T2AR_FLAG_OVF])
               | (external_event_flag_r & irq_en_r[`T2AR_FLAG_EXT] & ~updown);

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire [31:0] rd_data = hit_ctrl ? {29'h0000_0000, ctrl_r} :
                          hit_stat ? {30'h0000_0000, external_event_flag_r, overflow_flag_r} :
                          hit_en   ? {30'h0000_0000, irq_en_r} :
                          hit_rld  ? {16'h0000, reload_r} :
                          hit_cnt  ? {16'h0000, count_r} : 32'h0000_0000;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r   <= `T2AR_CTRL_RST;
            irq_en_r <= 2'b00;
            reload_r <= `T2AR_RELOAD_RST;
            prdata_r <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
                ctrl_r <= pwdata[2:0];
            if (wr_en)
                irq_en_r <= pwdata[1:0];
            // reload pair written only by software
            if (wr_rld)
                reload_r <= pwdata[15:0];
            if (setup_rd)
                prdata_r <= rd_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_r               <= `T2AR_COUNT_RST;
            overflow_flag_r       <= 1'b0;
            external_event_flag_r <= 1'b0;
            pin_prev_r            <= 1'b1;
            pre_r                 <= '0;
        end
        else if (clk_en)
        begin
            count_r               <= count_nxt;
            overflow_flag_r       <= overflow_flag_nxt;
            external_event_flag_r <= external_event_flag_nxt;
            pin_prev_r            <= external_trigger_pin;
            // prescaler runs only with run set
            if (!run_control_bit || tick)
                pre_r <= '0;
            else
                pre_r <= pre_r + PW'(1);
        end
    end

    assign count_value = count_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_up_overflow_flag:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && !updown && at_top |=> overflow_flag_r)
    else $error("overflow flag not set at top");

    a_up_reload_load:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && !updown && at_top && !wr_cnt |=> count_r == $past(reload_r))
    else $error("count not reloaded on overflow");

    a_trig_reload:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && run_control_bit && external_trigger_enable && !count_direction_enable
        && pin_prev_r && !external_trigger_pin && !wr_cnt
        |=> count_r == $past(reload_r))
    else $error("trigger edge did not reload");

    a_trig_flag_set:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && external_trigger_enable && !count_direction_enable
        && pin_prev_r && !external_trigger_pin |=> external_event_flag_r)
    else $error("trigger edge did not set external flag");

    a_up_irq_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
        !updown && external_event_flag_r && irq_en_r[`T2AR_FLAG_EXT] |-> irq)
    else $error("external flag did not raise irq");

    a_irq_or_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> overflow_flag_r || external_event_flag_r)
    else $error("irq without flag");

    a_dir_up_step:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && updown && external_trigger_pin && !at_top && !wr_cnt
        |=> count_r == $past(count_r) + 16'h0001)
    else $error("up count step wrong");

    a_dir_up_wrap:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && updown && external_trigger_pin && at_top && !wr_cnt
        |=> overflow_flag_r && count_r == $past(reload_r))
    else $error("up/down overflow wrong");

    a_dir_down_step:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && updown && !external_trigger_pin && !at_bottom && !wr_cnt
        |=> count_r == $past(count_r) - 16'h0001)
    else $error("down count step wrong");

    a_dir_underflow:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick && updown && !external_trigger_pin && at_bottom && !wr_cnt
        |=> overflow_flag_r && count_r == 16'hFFFF)
    else $error("underflow did not load top");

    a_ext_toggle:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && updown && wrap_any |=> external_event_flag_r != $past(external_event_flag_r))
    else $error("external flag did not toggle");

    a_dir_no_ext_irq:
    assert property (@(posedge pclk) disable iff (!presetn)
        updown && !(overflow_flag_r && irq_en_r[`T2AR_FLAG_OVF]) |-> !irq)
    else $error("external flag raised irq in up/down mode");

    a_flag_sticky:
    assert property (@(posedge pclk) disable iff (!presetn)
        overflow_flag_r && !clr_ovf |=> overflow_flag_r)
    else $error("overflow flag dropped without clear");

    a_tick_spacing:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && tick |=> !tick)
    else $error("ticks too close");

    a_run_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
        !run_control_bit && !wr_cnt |=> $stable(count_r))
    else $error("count moved while stopped");

    a_freeze_count:
    assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(count_r) && $stable(pre_r))
    else $error("count moved while clock enable low");

    a_freeze_flags:
    assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(overflow_flag_r) && $stable(external_event_flag_r))
    else $error("flags moved while clock enable low");

    a_ovf_clear:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && clr_ovf && !wrap_any |=> !overflow_flag_r)
    else $error("overflow flag survived a clear");

    a_ext_clear:
    assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && clr_ext && !trig_evt && !(updown && wrap_any) |=> !external_event_flag_r)
    else $error("external flag survived a clear");

    a_ovf_irq:
    assert property (@(posedge pclk) disable iff (!presetn)
        overflow_flag_r && irq_en_r[`T2AR_FLAG_OVF] |-> irq)
    else $error("overflow flag did not raise irq");

    a_stop_no_wrap:
    assert property (@(posedge pclk) disable iff (!presetn)
        !run_control_bit && !overflow_flag_r |=> !overflow_flag_r)
    else $error("overflow flag set while stopped");

    a_ext_flag_quiet:
    assert property (@(posedge pclk) disable iff (!presetn)
        !external_event_flag_r && !(count_direction_enable && wrap_any)
        && !(external_trigger_enable && pin_prev_r && !external_trigger_pin)
        |=> !external_event_flag_r)
    else $error("external flag set without an event");

endmodule : t2ar_timer

/* File: sim/t2ar_pin_model.sv */
// trigger pin source standing at the far side of the reload timer
`timescale 1ns/10ps

module t2ar_pin_model
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic level_req,
    output logic      pin
);
    // level steers direction, a 1-to-0 step triggers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pin <= 1'b1;
        else
            pin <= level_req;
    end
endmodule : t2ar_pin_model

/* File: sim/timer2_autoreload_updown_test.sv */
// self-checking bench of the reload timer
`timescale 1ns/10ps
`include "t2ar_defines.svh"

module timer2_autoreload_updown_test;
    import t2ar_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        level_req = 1'b1;
    logic        clk_en = 1'b1;
    t2ar_word_t  count_value;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          fail_count = 0;
    int          checks = 0;
    int          cycles = 0;

    always #2 pclk = ~pclk;

    t2ar_timer #(.CLKS_PER_TICK(2)) t2ar_timer_i (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_trigger_pin(pin), .count_value(count_value), .irq(irq));

    t2ar_pin_model t2ar_pin_model_i (.pclk(pclk), .presetn(presetn),
        .level_req(level_req), .pin(pin));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task finish_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wait_count(input t2ar_word_t v);
        int n;
        n = 0;
        while (count_value !== v && n < 300)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("count", {16'h0000, count_value}, {16'h0000, v});
    endtask : wait_count

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        apb(1'b0, `T2AR_OFS_COUNT, 32'h0000_0000);
        check("count reset", rd, 32'h0000_0000);
        check("irq reset", {31'h0, irq}, 32'h0000_0000);
        apb(1'b0, 8'h1C, 32'h0000_0000);
        check("unmapped err", {31'h0, err}, 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
    endtask : t_reset

    task t_up_reload;
        int         n;
        t2ar_word_t v;
        n = 0;
        apb(1'b1, `T2AR_OFS_RELOAD, 32'h0000_1234);
        apb(1'b1, `T2AR_OFS_COUNT, 32'h0000_FFFE);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0001);
        wait_count(16'hFFFF);
        while (count_value === 16'hFFFF && n < 50)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("tick spacing", n, 32'h0000_0002);
        check("up reload", {16'h0000, count_value}, 32'h0000_1234);
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("ovf flag", rd, 32'h0000_0001);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0000);
        #1;
        v = count_value;
        repeat (10) @(posedge pclk);
        #1;
        check("hold stopped", {16'h0000, count_value}, {16'h0000, v});
    endtask : t_up_reload

    task t_irq;
        apb(1'b1, `T2AR_OFS_IRQ_EN, 32'h0000_0001);
        #1;
        check("irq ovf", {31'h0, irq}, 32'h0000_0001);
        repeat (20) @(posedge pclk);
        #1;
        check("irq sticky", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `T2AR_OFS_CLEAR, 32'h0000_0001);
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("cleared", rd, 32'h0000_0000);
        check("irq low", {31'h0, irq}, 32'h0000_0000);
    endtask : t_irq

    task t_trigger;
        apb(1'b1, `T2AR_OFS_RELOAD, 32'h0000_0100);
        apb(1'b1, `T2AR_OFS_COUNT, 32'h0000_0010);
        apb(1'b1, `T2AR_OFS_IRQ_EN, 32'h0000_0002);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0003);
        level_req <= 1'b0;
        repeat (4) @(posedge pclk);
        #1;
        check("trig reload", {31'h0, count_value >= 16'h0100 && count_value <= 16'h0103},
            32'h0000_0001);
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("ext flag", rd, 32'h0000_0002);
        check("irq ext", {31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0000);
        apb(1'b1, `T2AR_OFS_CLEAR, 32'h0000_0003);
        level_req <= 1'b1;
    endtask : t_trigger

    task t_updown;
        apb(1'b1, `T2AR_OFS_RELOAD, 32'h0000_0010);
        apb(1'b1, `T2AR_OFS_COUNT, 32'h0000_FFFE);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0005);
        wait_count(16'hFFFF);
        wait_count(16'h0010);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0004);
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("up wrap flags", rd, 32'h0000_0003);
        check("no ext irq", {31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `T2AR_OFS_CLEAR, 32'h0000_0001);
        level_req <= 1'b0;
        apb(1'b1, `T2AR_OFS_COUNT, 32'h0000_0012);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0005);
        wait_count(16'h0011);
        wait_count(16'hFFFF);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0004);
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("down wrap flags", rd, 32'h0000_0001);
    endtask : t_updown

    task t_freeze;
        t2ar_word_t v;
        apb(1'b1, `T2AR_OFS_COUNT, 32'h0000_0100);
        apb(1'b1, `T2AR_OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        #1;
        v = count_value;
        repeat (10) @(posedge pclk);
        #1;
        check("freeze count", {16'h0000, count_value}, {16'h0000, v});
        @(posedge pclk);
        clk_en <= 1'b1;
        wait_count(v + 16'h0001);
    endtask : t_freeze

    task t_reset_mid;
        apb(1'b1, `T2AR_OFS_IRQ_EN, 32'h0000_0001);
        #1;
        check("irq before reset", {31'h0, irq}, 32'h0000_0001);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        check("reset count", {16'h0000, count_value}, 32'h0000_0000);
        check("reset irq", {31'h0, irq}, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `T2AR_OFS_STATUS, 32'h0000_0000);
        check("reset flags", rd, 32'h0000_0000);
        apb(1'b0, `T2AR_OFS_CTRL, 32'h0000_0000);
        check("reset ctrl", rd, 32'h0000_0000);
        repeat (6) @(posedge pclk);
        #1;
        check("reset hold", {16'h0000, count_value}, 32'h0000_0000);
    endtask : t_reset_mid

    // ----------------------------------------------------------------
    // timeout and main sequence
    // ----------------------------------------------------------------
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_up_reload();
        t_irq();
        t_trigger();
        t_updown();
        t_freeze();
        t_reset_mid();
        finish_test();
    end
endmodule : timer2_autoreload_updown_test
